// ### rtl/swc_pkg.sv
package swc_pkg;
	// sleep feature configuration
	typedef enum logic [1:0]
	{
		SWC_SLEEP_OFF    = 2'h0,
		SWC_WITH_FILTER  = 2'h1,
		SWC_RAW_INPUT    = 2'h2
	} swc_mode_e;

	// per-pin sleep behaviour codes
	localparam logic [2:0] SWC_HIZ_NO_PULL       = 3'h0;
	localparam logic [2:0] SWC_HIZ_WITH_PULLUP   = 3'h1;
	localparam logic [2:0] SWC_HIZ_WITH_PULLDOWN = 3'h2;
	localparam logic [2:0] SWC_HIZ_WITH_KEEPER   = 3'h3;
	localparam logic [2:0] SWC_HOLD_LAST         = 3'h4;

	localparam int          SWC_NUM_WAKE   = 8;
	localparam int          SWC_NUM_IO     = 8;
	localparam int          SWC_CNT_W      = 11;
	localparam logic [7:0]  SWC_MASK_RST   = 8'hFF;
	// release counts, in wake-clock cycles, range 1..1024
	localparam logic [10:0] SWC_OUT_REL_DEF = 11'h004;
	localparam logic [10:0] SWC_WR_REL_DEF  = 11'h005;
	// write lock delay, ns, and its cycle count at 25 MHz (40 ns)
	localparam int          SWC_CLK_NS         = 40;
	localparam int          SWC_WRITE_LOCK_NS  = 120;
	localparam logic [3:0]  SWC_WRITE_LOCK_CYC = 4'((SWC_WRITE_LOCK_NS + SWC_CLK_NS - 1) / SWC_CLK_NS);
	// glitch filter needs this many equal samples
	localparam logic [3:0]  SWC_FILT_LEN = 4'h4;

	typedef enum logic [2:0]
	{
		SWC_RUN      = 3'h0,
		SWC_WAIT_ACK = 3'h1,
		SWC_LOCKING  = 3'h2,
		SWC_ASLEEP   = 3'h3,
		SWC_WAKE_IN  = 3'h4,
		SWC_RELEASE  = 3'h5
	} swc_state_e;
endpackage : swc_pkg

// ### rtl/swc_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a bundle of pin levels
module swc_sync #(parameter int W = 1)
(
	input  wire logic         REF_CLK,
	input  wire logic         SRST,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;

	// first stage feeds only the second
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : swc_sync

// ### rtl/swc_filter.sv
`timescale 1ns/10ps
// glitch filter: output follows input only after a stable run
module swc_filter
	import swc_pkg::*;
(
	input  wire logic REF_CLK,
	input  wire logic SRST,
	input  wire logic din,
	output logic      dout
);
	logic [3:0] run_ff;
	wire        differs = (din != dout);

	// restart the run whenever input matches output again
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			run_ff <= 4'h0;
			dout   <= 1'b0;
		end
		else if (!differs)
			run_ff <= 4'h0;
		else if (run_ff == SWC_FILT_LEN - 4'h1)
		begin
			run_ff <= 4'h0;
			dout   <= din;
		end
		else
			run_ff <= run_ff + 4'h1;
	end
endmodule : swc_filter

// ### rtl/swc_ctrl.sv
`timescale 1ns/10ps
// Contract
// - sleep request pin ignored unless sleep feature enabled
// - mode is off, with_glitch_filter, or raw input
// - awake pin is user I/O when off, status when enabled
// - without multi-pin wake, sleep request level alone governs sleep
// - multi-pin wake on masked rising edges of eight pins
// - per-pin sleep setting, default high impedance no pull
// - hold-last pins drive latched value captured at entry
// - high impedance with pull-up, pull-down or keeper options
// - differential drivers go high impedance; hold-last unsupported
// - differential receivers and termination off while asleep
// - after write lock delay, storage write-protected and retained
// - write lock lifted at write release count on wake
// - optional global set/reset on wake, default off
// - write enable removal is first action after request
// - storage may still update during write lock delay
// - with handshake, entry waits for sleep acknowledge
// - inputs re-enabled before write enable restored
// - sleep request output raised after sleep request pin asserted; here raised only with handshake enabled, while in WAIT_ACK
// - awake status low while asleep
// - outputs released output release count after awake high
// - storage released write release count after awake high
module swc_ctrl
	import swc_pkg::*;
(
	input  wire logic                      REF_CLK,
	input  wire logic                      SRST,
	input  wire swc_pkg::swc_mode_e        SLEEP_MODE,
	input  wire logic                      MULTI_WAKE_EN,
	input  wire logic [7:0]                WAKE_MASK,
	input  wire logic                      HANDSHAKE_EN,
	input  wire logic                      WAKE_GLOBAL_INIT_EN,
	input  wire logic [10:0]               OUTPUT_RELEASE_COUNT,
	input  wire logic [10:0]               WRITE_RELEASE_COUNT,
	input  wire logic                      SLEEP_PIN,
	input  wire logic [7:0]                WAKE_SOURCE_PIN,
	input  wire logic                      SLEEP_ACK,
	output logic                           SLEEP_REQ,
	input  wire logic [23:0]               IO_SLEEP_CFG,
	input  wire logic [7:0]                IO_DIFF,
	input  wire logic [7:0]                IO_OUT,
	input  wire logic [7:0]                IO_OE,
	output logic      [7:0]                PAD_OUT,
	output logic      [7:0]                PAD_OE,
	output logic      [7:0]                PAD_PULLUP,
	output logic      [7:0]                PAD_PULLDOWN,
	output logic      [7:0]                PAD_KEEPER,
	output logic                           DIFF_RX_EN,
	output logic                           DIFF_TERM_EN,
	input  wire logic                      AWAKE_USER_OUT,
	input  wire logic                      AWAKE_USER_OE,
	output logic                           AWAKE_OUT,
	output logic                           AWAKE_OE,
	output logic                           WRITE_EN,
	output logic                           INPUT_EN,
	output logic                           GLOBAL_INIT,
	output logic                           OUTPUTS_SLEEPING
);
	// sequencer state and its next value
	// entry runs RUN, optional WAIT_ACK, LOCKING, ASLEEP
	// exit runs WAKE_IN, then RELEASE until both counts expire
	swc_state_e  state_ff;
	swc_state_e  nxt_state;
	logic        sleep_sync;
	logic        sleep_filt;
	logic [7:0]  wake_sync;
	logic [7:0]  wake_prev_ff;
	logic [10:0] cnt_ff;
	logic [7:0]  held_ff;
	logic        wr_en_ff;
	logic        in_en_ff;
	logic        awake_ff;
	logic        out_sleep_ff;
	logic        init_ff;

	// the global controls are all flops, so each changes on a clean edge
	// and no combinational glitch can unlock storage for part of a cycle
	// the pad outputs stay combinational: they must follow IO_OUT with no
	// added latency while the device is awake

	// pins are asynchronous; two flops before any use
	// pin synchronisers
	swc_sync #(.W(1)) u_sleep_sync
	(
		.REF_CLK  (REF_CLK),
		.SRST     (SRST),
		.async_in (SLEEP_PIN),
		.sync_out (sleep_sync)
	);

	swc_sync #(.W(8)) u_wake_sync
	(
		.REF_CLK  (REF_CLK),
		.SRST     (SRST),
		.async_in (WAKE_SOURCE_PIN),
		.sync_out (wake_sync)
	);

	// the filter always runs, even with the feature off, so switching
	// modes never starts from a stale with_glitch_filter level
	// limitation: a pulse shorter than the filter length is lost in mode 1
	swc_filter u_filter
	(
		.REF_CLK (REF_CLK),
		.SRST    (SRST),
		.din     (sleep_sync),
		.dout    (sleep_filt)
	);

	// request selection per mode
	// off ignores pin
	wire sleep_on  = (SLEEP_MODE == SWC_WITH_FILTER) || (SLEEP_MODE == SWC_RAW_INPUT);
	wire sleep_lvl = (SLEEP_MODE == SWC_WITH_FILTER) ? sleep_filt : sleep_sync;
	wire sleep_rq  = sleep_on && sleep_lvl;

	// edge history resets low, matching the idle level of the wake pins,
	// so no false edge appears right after reset
	// masked rising edges
	wire [7:0] wake_rise = wake_sync & ~wake_prev_ff & WAKE_MASK;
	wire wake_go = MULTI_WAKE_EN ? (!sleep_rq && (|wake_rise)) : !sleep_rq;

	// zero would release on the first count, the same as one; treat it as one
	// counts run in the single clock; a slower wake clock would need an
	// enable pulse here instead
	wire [10:0] out_rel = (OUTPUT_RELEASE_COUNT == 11'h000) ? 11'h001 : OUTPUT_RELEASE_COUNT;
	wire [10:0] wr_rel  = (WRITE_RELEASE_COUNT == 11'h000) ? 11'h001 : WRITE_RELEASE_COUNT;
	wire [10:0] cnt_inc = cnt_ff + 11'h001;
	wire        lock_done = (cnt_ff[3:0] == SWC_WRITE_LOCK_CYC - 4'h1);
	wire        rel_done  = (cnt_inc >= wr_rel) && (cnt_inc >= out_rel);

	// sleep sequencer
	// a request that drops while waiting for acknowledge aborts entry;
	// once locking has begun the sequence always completes
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			SWC_RUN:
				// wait for acknowledge when handshake used
				if (sleep_rq)
					nxt_state = HANDSHAKE_EN ? SWC_WAIT_ACK : SWC_LOCKING;
			SWC_WAIT_ACK:
				if (!sleep_rq)
					nxt_state = SWC_RUN;
				else if (SLEEP_ACK)
					nxt_state = SWC_LOCKING;
			SWC_LOCKING:
				// storage still writable until delay ends
				if (lock_done)
					nxt_state = SWC_ASLEEP;
			SWC_ASLEEP:
				if (wake_go)
					nxt_state = SWC_WAKE_IN;
			SWC_WAKE_IN:
				nxt_state = SWC_RELEASE;
			SWC_RELEASE:
				if (rel_done)
					nxt_state = SWC_RUN;
			default:
				nxt_state = SWC_RUN;
		endcase
	end

	// state and sleep-entry/wake counter
	// the counter restarts on every state change, so each phase measures
	// its own delay from zero; it may wrap harmlessly while asleep
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			state_ff <= SWC_RUN;
			cnt_ff   <= 11'h000;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= (nxt_state != state_ff) ? 11'h000 : cnt_inc;
		end
	end

	// previous synchronised wake levels for edge detection
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			wake_prev_ff <= 8'h00;
		else
			wake_prev_ff <= wake_sync;
	end

	// global controls; order on entry: write lock, then awake low, outputs and inputs on one edge
	// exit: inputs, awake high, then outputs and writes, each at its own release count
	// keeping writes locked until the write release count lets user control signals settle
	// before any storage element can change
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			wr_en_ff     <= 1'b1;
			in_en_ff     <= 1'b1;
			awake_ff     <= 1'b1;
			out_sleep_ff <= 1'b0;
			init_ff      <= 1'b0;
		end
		else
		begin
			init_ff <= 1'b0;
			case (state_ff)
				SWC_LOCKING:
					if (lock_done)
						wr_en_ff <= 1'b0;
				SWC_ASLEEP:
				begin
					awake_ff     <= 1'b0;
					out_sleep_ff <= 1'b1;
					in_en_ff     <= wake_go;
				end
				SWC_WAKE_IN:
				begin
					in_en_ff <= 1'b1;
					awake_ff <= 1'b1;
					init_ff  <= WAKE_GLOBAL_INIT_EN;
				end
				SWC_RELEASE:
				begin
					if (cnt_inc >= out_rel)
						out_sleep_ff <= 1'b0;
					if (cnt_inc >= wr_rel)
						wr_en_ff <= 1'b1;
				end
				default:
				begin
					wr_en_ff     <= wr_en_ff;
				end
			endcase
		end
	end

	// capture output latch value at sleep entry
	// captured on the same edge that locks writes, so the held level is
	// exactly the last value the output latch could store
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			held_ff <= 8'h00;
		else if (wr_en_ff && (state_ff == SWC_LOCKING) && lock_done)
			held_ff <= IO_OUT;
	end

	// per-pin sleep behaviour; differential pins refuse hold-last
	// unknown codes fall back to plain high impedance with no pull
	// pseudo-differential pairs are two plain pins here; their codes are
	// the user's duty to keep consistent
	genvar gi;
	generate
		for (gi = 0; gi < SWC_NUM_IO; gi++)
		begin : g_pin
			wire [2:0] cfg  = IO_SLEEP_CFG[gi*3 +: 3];
			wire       hold = (cfg == SWC_HOLD_LAST) && !IO_DIFF[gi];
			assign PAD_OUT[gi]      = out_sleep_ff ? (hold & held_ff[gi]) : IO_OUT[gi];
			assign PAD_OE[gi]       = out_sleep_ff ? hold : IO_OE[gi];
			assign PAD_PULLUP[gi]   = out_sleep_ff && (cfg == SWC_HIZ_WITH_PULLUP);
			assign PAD_PULLDOWN[gi] = out_sleep_ff && (cfg == SWC_HIZ_WITH_PULLDOWN);
			assign PAD_KEEPER[gi]   = out_sleep_ff && (cfg == SWC_HIZ_WITH_KEEPER);
		end
	endgenerate

	// receivers and termination share the input enable, saving static
	// power for exactly the span in which inputs are blocked
	// differential receivers off asleep
	assign DIFF_RX_EN   = in_en_ff;
	assign DIFF_TERM_EN = in_en_ff;

	// awake pin use by mode
	// with the feature on the pin is always driven, never left open
	assign AWAKE_OUT = sleep_on ? awake_ff : AWAKE_USER_OUT;
	assign AWAKE_OE  = sleep_on ? 1'b1 : AWAKE_USER_OE;

	// status outputs straight from their flops; SLEEP_REQ is decoded from the state
	// request toward user logic
	assign SLEEP_REQ        = (state_ff == SWC_WAIT_ACK);
	assign WRITE_EN         = wr_en_ff;
	assign INPUT_EN         = in_en_ff;
	assign GLOBAL_INIT      = init_ff;
	assign OUTPUTS_SLEEPING = out_sleep_ff;
endmodule : swc_ctrl

// ### tb/swc_ctrl_monitor.sv
`timescale 1ns/10ps
// watches entry and exit ordering and pad states while asleep
module swc_ctrl_monitor
	import swc_pkg::*;
(
	input wire logic		REF_CLK,
	input wire logic		SRST,
	input wire swc_pkg::swc_mode_e	SLEEP_MODE,
	input wire logic		WAKE_GLOBAL_INIT_EN,
	input wire logic [10:0]		OUTPUT_RELEASE_COUNT,
	input wire logic [10:0]		WRITE_RELEASE_COUNT,
	input wire logic [23:0]		IO_SLEEP_CFG,
	input wire logic [7:0]		IO_DIFF,
	input wire logic [7:0]		PAD_OUT,
	input wire logic [7:0]		PAD_OE,
	input wire logic [7:0]		PAD_PULLUP,
	input wire logic [7:0]		PAD_PULLDOWN,
	input wire logic [7:0]		PAD_KEEPER,
	input wire logic		DIFF_RX_EN,
	input wire logic		DIFF_TERM_EN,
	input wire logic		AWAKE_OUT,
	input wire logic		WRITE_EN,
	input wire logic		INPUT_EN,
	input wire logic		GLOBAL_INIT,
	input wire logic		OUTPUTS_SLEEPING
);
	logic [7:0]	pu, pd, kp, hm, se;
	logic		on;

	// pulls only judged on single-ended pins; diff pin pulls are left open
	assign on = SLEEP_MODE != SWC_SLEEP_OFF;
	assign se = ~IO_DIFF;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			pu[i] = IO_SLEEP_CFG[3*i+:3] == SWC_HIZ_WITH_PULLUP;
			pd[i] = IO_SLEEP_CFG[3*i+:3] == SWC_HIZ_WITH_PULLDOWN;
			kp[i] = IO_SLEEP_CFG[3*i+:3] == SWC_HIZ_WITH_KEEPER;
			hm[i] = IO_SLEEP_CFG[3*i+:3] == SWC_HOLD_LAST && se[i];
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);

	chk_lock_first:
		assert property (on && $fell(AWAKE_OUT) |-> !WRITE_EN) else $error("awake fell before write lock");
	chk_in_before_wr:
		assert property ($rose(WRITE_EN) |-> INPUT_EN && $past(INPUT_EN)) else $error("write before inputs");
	chk_awake_low:
		assert property (on && !INPUT_EN |-> !AWAKE_OUT) else $error("awake high while asleep");
	chk_diff_rx_off:
		assert property (!INPUT_EN |-> !DIFF_RX_EN && !DIFF_TERM_EN) else $error("diff receiver on");
	chk_diff_hiz:
		assert property (OUTPUTS_SLEEPING |-> (PAD_OE & IO_DIFF) == 8'h00) else $error("diff driver on");
	chk_hiz_default:
		assert property (OUTPUTS_SLEEPING |-> (PAD_OE & ~hm) == 8'h00) else $error("pad driven in sleep");
	chk_pull_codes:
		assert property (OUTPUTS_SLEEPING |-> (((PAD_PULLUP ^ pu) | (PAD_PULLDOWN ^ pd) | (PAD_KEEPER ^ kp)) & se)
			== 8'h00) else $error("pull setting wrong");
	chk_hold_last:
		assert property (OUTPUTS_SLEEPING && $past(OUTPUTS_SLEEPING) |-> (PAD_OE & hm) == hm
			&& ((PAD_OUT ^ $past(PAD_OUT)) & hm) == 8'h00) else $error("held level moved");
	chk_out_first:
		assert property ($rose(WRITE_EN) && OUTPUT_RELEASE_COUNT <= WRITE_RELEASE_COUNT |-> !OUTPUTS_SLEEPING)
			else $error("write released before outputs");
	chk_init_gate:
		assert property (GLOBAL_INIT |-> WAKE_GLOBAL_INIT_EN && !WRITE_EN) else $error("stray global init");
endmodule : swc_ctrl_monitor

bind swc_ctrl swc_ctrl_monitor i_swc_ctrl_monitor (.*);

// ### tb/swc_partner.sv
`timescale 1ns/10ps
// user logic side: acknowledges a sleep request after a settable delay
module swc_partner
(
	input  wire logic	REF_CLK,
	input  wire logic	SRST,
	input  wire logic	SLEEP_REQ,
	input  wire logic [3:0]	ACK_DELAY,
	output logic		SLEEP_ACK
);
	logic [3:0]	wait_ff;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST || !SLEEP_REQ)
		begin
			wait_ff   <= 4'h0;
			SLEEP_ACK <= 1'b0;
		end
		else if (wait_ff == ACK_DELAY)
			SLEEP_ACK <= 1'b1;
		else
			wait_ff <= wait_ff + 4'h1;
	end
endmodule : swc_partner

// ### tb/tb_top.sv
`timescale 1ns/10ps
// drives sleep and wake sequences; a watcher checks the release counts
module tb_top;
	import swc_pkg::*;
	swc_mode_e	mode;
	logic		clk, srst, mw, hs, gi, pin, ack, req, rx, tm, awu, awue, awo, awoe, we, ie, gin, osl, we_q, gseen;
	logic [7:0]	mk, wsp, dif, iout, ioe, pout, poe, ppu, ppd, pkp, hm, held;
	logic [10:0]	oc, wc;
	logic [21:0]	nt;
	logic [21:0]	notes[$];
	logic [23:0]	cfg;
	logic [3:0]	ackd;
	integer		seed = 32'hA095;
	int		miscompares, tests_run, cycles, n_out, n_wr;

	swc_ctrl i_swc_ctrl (.REF_CLK(clk), .SRST(srst), .SLEEP_MODE(mode), .MULTI_WAKE_EN(mw), .WAKE_MASK(mk),
		.HANDSHAKE_EN(hs), .WAKE_GLOBAL_INIT_EN(gi), .OUTPUT_RELEASE_COUNT(oc), .WRITE_RELEASE_COUNT(wc),
		.SLEEP_PIN(pin), .WAKE_SOURCE_PIN(wsp), .SLEEP_ACK(ack), .SLEEP_REQ(req), .IO_SLEEP_CFG(cfg),
		.IO_DIFF(dif), .IO_OUT(iout), .IO_OE(ioe), .PAD_OUT(pout), .PAD_OE(poe), .PAD_PULLUP(ppu),
		.PAD_PULLDOWN(ppd), .PAD_KEEPER(pkp), .DIFF_RX_EN(rx), .DIFF_TERM_EN(tm), .AWAKE_USER_OUT(awu),
		.AWAKE_USER_OE(awue), .AWAKE_OUT(awo), .AWAKE_OE(awoe), .WRITE_EN(we), .INPUT_EN(ie),
		.GLOBAL_INIT(gin), .OUTPUTS_SLEEPING(osl));
	swc_partner i_swc_partner (.REF_CLK(clk), .SRST(srst), .SLEEP_REQ(req), .ACK_DELAY(ackd), .SLEEP_ACK(ack));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	// inputs always move 2 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step

	task automatic wait_on(input int sel, input logic lvl);
		int n;
		n = 0;
		while ((sel == 0 ? ie : sel == 1 ? req : we) !== lvl && n < 300)
		begin
			step(1);
			n++;
		end
		check(n < 300, 1'b1);
	endtask : wait_on

	task automatic sleep_wake;
		held = iout;
		gseen = 1'b0;
		pin = 1'b1;
		if (hs)
		begin
			wait_on(1, 1'b1);
			check(we, 1'b1);
		end
		wait_on(0, 1'b0);
		step(1);
		check({we, awo, rx, tm}, 4'h0);
		iout = ~held;
		step(3);
		check(pout & hm, held & hm);
		notes.push_back({wc, oc});
		// wake exit driven just after a bench clock edge
		pin = 1'b0;
		if (mw)
		begin
			step(10);
			wsp = ~mk;
			step(10);
			check(ie, 1'b0);
			wsp = mk ^ (mk >> 1);
			step(3);
			wsp = 8'h00;
		end
		wait_on(0, 1'b1);
		wait_on(2, 1'b1);
		step(1);
		check(gseen, gi);
		check({pout, poe}, {iout, ioe});
	endtask : sleep_wake

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// counts cycles from awake high to each release; checked when write enable rises
	always @(posedge clk)
	begin
		if (gin)
			gseen = 1'b1;
		if (we && !we_q && notes.size() > 0)
		begin
			nt = notes.pop_front();
			check(n_out, nt[10:0]);
			check(n_wr, nt[21:11]);
		end
		n_out = awo ? n_out + int'(osl) : 0;
		n_wr = awo ? n_wr + int'(!we) : 0;
		we_q = we;
	end

	// a hang counts as a mismatch and closes the run
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			stop_test();
		end
	end

	initial
	begin
		srst = 1'b1;
		mode = SWC_SLEEP_OFF;
		{mw, hs, gi, pin, wsp, mk, cfg, dif, iout, ioe, ackd} = '0;
		{awu, awue, gseen} = 3'h6;
		oc = SWC_OUT_REL_DEF;
		wc = SWC_WR_REL_DEF;
		step(8);
		srst = 1'b0;
		step(4);
		// with the feature off the pin is ignored and awake is a user pin
		pin = 1'b1;
		repeat (20)
		begin
			{awu, awue} = 2'($random(seed));
			step(1);
			check({awo, awoe}, {awu, awue});
			check({we, ie}, 2'h3);
		end
		{pin, awu, awue} = 3'h3;
		step(4);
		for (int k = 0; k < 6; k++)
		begin
			mode = k[0] ? SWC_WITH_FILTER : SWC_RAW_INPUT;
			hs = k[1];
			mw = k >= 4;
			mk = k[0] ? 8'hFF : 8'h0F;
			{gi, ackd, iout, ioe} = 21'($random(seed));
			oc = 11'h001 + 11'($unsigned($random(seed)) % 4);
			wc = oc + 11'($unsigned($random(seed)) % 4);
			dif = k[0] ? 8'hC0 : 8'h00;
			for (int i = 0; i < 8; i++)
				cfg[3*i+:3] = 3'($unsigned($random(seed)) % 5);
			cfg[23:21] = cfg[20:18];
			for (int i = 0; i < 8; i++)
				hm[i] = cfg[3*i+:3] == SWC_HOLD_LAST && !dif[i];
			step(6);
			sleep_wake();
		end
		// a two-cycle blip must not get through the filter
		mode = SWC_WITH_FILTER;
		mw = 1'b0;
		step(4);
		pin = 1'b1;
		step(2);
		pin = 1'b0;
		step(20);
		check({we, ie, awo}, 3'h7);
		stop_test();
	end
endmodule : tb_top
